// ### rtl/mbr_pkg.sv
// Shared constants, types and CRC helper for the register responder
package mbr_pkg;

	// ----------------------------------------
	// Line timing
	// ----------------------------------------
	localparam int SYS_CLK_HZ = 250_000_000;
	localparam int BAUD_RATE = 19200;
	localparam int BIT_CYCLES_DEF = (SYS_CLK_HZ + BAUD_RATE / 2) / BAUD_RATE;
	localparam int CHAR_BITS = 11;
	localparam int GAP_CHAR_TENTHS = 35;
	// Least time, so round up
	localparam int GAP_CYCLES_DEF = (BIT_CYCLES_DEF * CHAR_BITS * GAP_CHAR_TENTHS + 9) / 10;

	// ----------------------------------------
	// Frame layout
	// ----------------------------------------
	localparam int QUERY_BYTES = 8;
	localparam int Q_ADDR = 0;
	localparam int Q_FUNC = 1;
	localparam int Q_START_HI = 2;
	localparam int Q_START_LO = 3;
	localparam int Q_COUNT_HI = 4;
	localparam int Q_COUNT_LO = 5;
	localparam int REPLY_HDR_BYTES = 3;
	localparam logic [7:0] FUNC_READ_HOLDING = 8'h03;
	localparam logic [15:0] MAX_REG_COUNT = 16'h007d;
	localparam logic [15:0] CRC_INIT = 16'hffff;
	localparam logic [15:0] CRC_POLY = 16'ha001;

	// ----------------------------------------
	// Holding register map
	// ----------------------------------------
	localparam int REG_NUMBER_BASE = 40001;
	localparam logic [15:0] PH_LOW_ADDR = 16'h0006;
	localparam logic [15:0] PH_HIGH_ADDR = 16'h0007;
	localparam int NUM_FLOATS_DEF = 4;
	localparam int FIFO_DEPTH_DEF = 32;
	localparam int BYTE_W = 8;

	typedef struct packed {
		logic [15:0] high_word;
		logic [15:0] low_word;
	} mbr_float_type;

	function automatic logic [15:0] mbr_crc_update(input logic [15:0] crc, input logic [7:0] data);
		logic [15:0] c;
		c = crc ^ {8'h00, data};
		for (int i = 0; i < 8; i++) begin
			c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
		end
		return c;
	endfunction

endpackage

// ### rtl/mbr_fifo.sv
// Byte FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module mbr_fifo #(
	parameter int WIDTH = mbr_pkg::BYTE_W,
	parameter int DEPTH = mbr_pkg::FIFO_DEPTH_DEF
)(
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	import mbr_pkg::*;

	localparam int AW = $clog2(DEPTH);

	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_depth_check
		$error("FIFO depth must be a power of two, at least 2");
	end

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
	logic [AW:0] fill_reg, fill_next;
	logic push, pop;

	assign in_ready = (fill_reg != (AW+1)'(DEPTH));
	assign out_valid = (fill_reg != '0);
	assign out_data = mem[rd_ptr_reg];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_comb begin
		wr_ptr_next = push ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
		rd_ptr_next = pop ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
		fill_next = fill_reg + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			fill_reg <= '0;
		end else begin
			wr_ptr_reg <= wr_ptr_next;
			rd_ptr_reg <= rd_ptr_next;
			fill_reg <= fill_next;
		end
		if (push) begin
			mem[wr_ptr_reg] <= in_data;
		end
	end
endmodule
`default_nettype wire

// ### rtl/mbr_uart.sv
// Serial transmitter and receiver, 8 data bits, even parity, 1 stop bit
`timescale 1ns/1ps
`default_nettype none
module mbr_uart #(
	parameter int BIT_CYCLES = mbr_pkg::BIT_CYCLES_DEF
)(
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic rxd,
	output logic [7:0] rx_data,
	output logic rx_valid,
	output logic rx_error,
	input wire logic [7:0] tx_data,
	input wire logic tx_valid,
	output logic tx_ready,
	output logic txd,
	output logic tx_busy
);
	import mbr_pkg::*;

	localparam int CW = $clog2(BIT_CYCLES + 1);

	if (BIT_CYCLES < 4) begin : g_bit_check
		$error("Bit period too short");
	end

	typedef enum {RX_IDLE, RX_START, RX_SHIFT, RX_STOP} mbr_rx_state_type;

	// ----------------------------------------
	// Receiver
	// ----------------------------------------
	mbr_rx_state_type rx_state_reg, rx_state_next;
	logic [CW-1:0] rx_cnt_reg, rx_cnt_next;
	logic [3:0] rx_bits_reg, rx_bits_next;
	logic [8:0] rx_shift_reg, rx_shift_next;
	logic [7:0] rx_data_reg, rx_data_next;
	logic rx_valid_reg, rx_valid_next, rx_error_reg, rx_error_next;
	logic rx_tick;

	assign rx_tick = (rx_cnt_reg == '0);
	assign rx_data = rx_data_reg;
	assign rx_valid = rx_valid_reg;
	assign rx_error = rx_error_reg;

	always_comb begin
		rx_state_next = rx_state_reg;
		rx_cnt_next = rx_tick ? rx_cnt_reg : rx_cnt_reg - 1'b1;
		rx_bits_next = rx_bits_reg;
		rx_shift_next = rx_shift_reg;
		rx_data_next = rx_data_reg;
		rx_valid_next = 1'b0;
		rx_error_next = 1'b0;
		unique case (rx_state_reg)
			RX_IDLE: begin
				if (!rxd) begin
					rx_state_next = RX_START;
					rx_cnt_next = CW'(BIT_CYCLES / 2 - 1);
				end
			end
			RX_START: begin
				if (rx_tick) begin
					// A short low pulse is noise, not a start bit
					rx_state_next = rxd ? RX_IDLE : RX_SHIFT;
					rx_cnt_next = CW'(BIT_CYCLES - 1);
					rx_bits_next = '0;
				end
			end
			RX_SHIFT: begin
				if (rx_tick) begin
					rx_shift_next = {rx_shift_reg[7:0], rxd};
					rx_cnt_next = CW'(BIT_CYCLES - 1);
					rx_bits_next = rx_bits_reg + 1'b1;
					if (rx_bits_reg == 4'd8) begin
						rx_state_next = RX_STOP;
					end
				end
			end
			RX_STOP: begin
				if (rx_tick) begin
					rx_state_next = RX_IDLE;
					rx_valid_next = 1'b1;
					rx_data_next = rx_shift_reg[8:1];
					rx_error_next = !rxd || (^rx_shift_reg);
				end
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			rx_state_reg <= RX_IDLE;
			rx_cnt_reg <= '0;
			rx_bits_reg <= '0;
			rx_shift_reg <= '0;
			rx_data_reg <= '0;
			rx_valid_reg <= 1'b0;
			rx_error_reg <= 1'b0;
		end else begin
			rx_state_reg <= rx_state_next;
			rx_cnt_reg <= rx_cnt_next;
			rx_bits_reg <= rx_bits_next;
			rx_shift_reg <= rx_shift_next;
			rx_data_reg <= rx_data_next;
			rx_valid_reg <= rx_valid_next;
			rx_error_reg <= rx_error_next;
		end
	end

	// ----------------------------------------
	// Transmitter
	// ----------------------------------------
	logic [CW-1:0] tx_cnt_reg, tx_cnt_next;
	logic [3:0] tx_left_reg, tx_left_next;
	logic [9:0] tx_shift_reg, tx_shift_next;
	logic txd_reg, txd_next;

	assign tx_ready = (tx_left_reg == '0);
	assign tx_busy = !tx_ready;
	assign txd = txd_reg;

	always_comb begin
		tx_cnt_next = tx_cnt_reg;
		tx_left_next = tx_left_reg;
		tx_shift_next = tx_shift_reg;
		txd_next = txd_reg;
		if (tx_ready) begin
			if (tx_valid) begin
				txd_next = 1'b0;
				tx_shift_next = {tx_data, ^tx_data, 1'b1};
				tx_left_next = 4'(CHAR_BITS);
				tx_cnt_next = CW'(BIT_CYCLES - 1);
			end
		end else if (tx_cnt_reg == '0) begin
			tx_left_next = tx_left_reg - 1'b1;
			if (tx_left_reg != 4'd1) begin
				txd_next = tx_shift_reg[9];
				tx_shift_next = {tx_shift_reg[8:0], 1'b1};
				tx_cnt_next = CW'(BIT_CYCLES - 1);
			end
		end else begin
			tx_cnt_next = tx_cnt_reg - 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			tx_cnt_reg <= '0;
			tx_left_reg <= '0;
			tx_shift_reg <= '1;
			txd_reg <= 1'b1;
		end else begin
			tx_cnt_reg <= tx_cnt_next;
			tx_left_reg <= tx_left_next;
			tx_shift_reg <= tx_shift_next;
			txd_reg <= txd_next;
		end
	end
endmodule
`default_nettype wire

// ### rtl/mbr_responder.sv
// Holding-register read responder: query decode, reply build, port steering
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Link is 19200 baud, 8 bits, even, 1 stop
// - Answer function 3 on either serial port
// - Each measurement is a four-byte IEEE float
// - Float low word goes out before high word
// - Within a word, high byte goes first
// - Bits of each byte sent MSB first
// - Protocol address is register number minus 40001
// - Registers are 16 bits; float spans two
// - Reply opens with own address, then 03
// - Third reply byte is twice register count
// - Register value sent upper byte first
// - Reply ends with CRC over preceding bytes
// - RS232 always on; RS485 only when selected
// - RS485 and SDI-12 never drive together
// - Drive shared pair only while replying
// - pH readable at addresses 6 and 7
module mbr_responder #(
	parameter int BIT_CYCLES = mbr_pkg::BIT_CYCLES_DEF,
	parameter int GAP_CYCLES = mbr_pkg::GAP_CYCLES_DEF,
	parameter int NUM_FLOATS = mbr_pkg::NUM_FLOATS_DEF,
	parameter int FIFO_DEPTH = mbr_pkg::FIFO_DEPTH_DEF
)(
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic [7:0] slave_addr,
	input wire logic rs485_select,
	input wire logic sdi12_select,
	input wire mbr_pkg::mbr_float_type [NUM_FLOATS-1:0] meas_values,
	input wire logic rs232_rxd,
	input wire logic rs485_rxd,
	output logic rs232_txd,
	output logic rs485_txd,
	output logic rs485_oe,
	output logic reply_active,
	output logic [7:0] dropped_count
);
	import mbr_pkg::*;

	localparam int FW = $clog2(NUM_FLOATS);
	localparam int GW = $clog2(GAP_CYCLES + 1);
	localparam logic [16:0] NUM_REGS = 17'(NUM_FLOATS * 2);

	// ----------------------------------------
	// Elaboration checks
	// ----------------------------------------
	if (NUM_FLOATS < 1 || (1 << FW) != NUM_FLOATS || NUM_REGS <= 17'(PH_HIGH_ADDR)) begin : g_map_check
		$error("Float count must be a power of two covering the pH registers");
	end
	if (GAP_CYCLES < 2) begin : g_gap_check
		$error("Frame gap too short");
	end

	typedef enum {ST_LISTEN, ST_SEND, ST_DRAIN} mbr_state_type;

	// ----------------------------------------
	// Port steering and serial engine
	// ----------------------------------------
	logic rs485_active_reg, rs485_active_next;
	logic rs232_txd_reg, rs485_txd_reg, rs485_oe_reg;
	logic rs232_txd_next, rs485_txd_next, rs485_oe_next;
	// Registered from the next state so the flag keeps the state's timing
	logic reply_active_reg, reply_active_next;
	logic rx_line;
	logic [7:0] rx_data;
	logic rx_valid, rx_error;
	logic [7:0] fifo_in_data, fifo_out_data;
	logic fifo_in_valid, fifo_in_ready, fifo_out_valid;
	logic uart_tx_ready, uart_txd, uart_tx_busy;

	// The SDI-12 selection owns the shared contacts and wins over RS485
	assign rs485_active_next = rs485_select && !sdi12_select;
	// Idle-high lines merge by AND; a muted port reads as idle
	assign rx_line = rs232_rxd & (rs485_active_reg ? rs485_rxd : 1'b1);

	mbr_uart #(
		.BIT_CYCLES(BIT_CYCLES)
	) u_uart (
		.sys_clk(sys_clk),
		.reset(reset),
		.rxd(rx_line),
		.rx_data(rx_data),
		.rx_valid(rx_valid),
		.rx_error(rx_error),
		.tx_data(fifo_out_data),
		.tx_valid(fifo_out_valid),
		.tx_ready(uart_tx_ready),
		.txd(uart_txd),
		.tx_busy(uart_tx_busy)
	);

	mbr_fifo #(
		.WIDTH(BYTE_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.sys_clk(sys_clk),
		.reset(reset),
		.in_data(fifo_in_data),
		.in_valid(fifo_in_valid),
		.in_ready(fifo_in_ready),
		.out_data(fifo_out_data),
		.out_valid(fifo_out_valid),
		.out_ready(uart_tx_ready)
	);

	// ----------------------------------------
	// Query collection
	// ----------------------------------------
	mbr_state_type state_reg, state_next;
	logic [7:0] qbuf_reg [QUERY_BYTES];
	logic [7:0] qbuf_next [QUERY_BYTES];
	logic [3:0] qidx_reg, qidx_next;
	logic [15:0] rx_crc_reg, rx_crc_next;
	logic [GW-1:0] gap_reg, gap_next;
	logic bad_reg, bad_next;
	logic [15:0] start_reg, start_next, count_reg, count_next;
	logic [7:0] dropped_reg, dropped_next;
	logic [15:0] q_start, q_count;
	logic [16:0] q_end;
	logic query_ok;

	assign q_start = {qbuf_reg[Q_START_HI], qbuf_reg[Q_START_LO]};
	assign q_count = {qbuf_reg[Q_COUNT_HI], qbuf_reg[Q_COUNT_LO]};
	assign q_end = {1'b0, q_start} + {1'b0, q_count};
	// A good CRC leaves a zero residue over all eight bytes
	assign query_ok = !bad_reg && qidx_reg == 4'(QUERY_BYTES) && rx_crc_reg == 16'h0000
		&& qbuf_reg[Q_ADDR] == slave_addr && qbuf_reg[Q_FUNC] == FUNC_READ_HOLDING
		&& q_count != 16'h0000 && q_count <= MAX_REG_COUNT && q_end <= NUM_REGS;

	// ----------------------------------------
	// Reply generation
	// ----------------------------------------
	logic [7:0] seq_reg, seq_next;
	logic [15:0] tx_crc_reg, tx_crc_next;
	logic [7:0] byte_cnt, data_end, k;
	logic [15:0] rd_addr, rd_word;
	logic [7:0] reply_byte;

	assign byte_cnt = 8'(count_reg << 1);
	assign data_end = 8'(REPLY_HDR_BYTES) + byte_cnt;
	assign k = seq_reg - 8'(REPLY_HDR_BYTES);
	assign rd_addr = start_reg + {9'h000, k[7:1]};
	// Even address holds the float's low word, so low word goes first
	assign rd_word = rd_addr[0] ? meas_values[rd_addr[FW:1]].high_word
		: meas_values[rd_addr[FW:1]].low_word;

	always_comb begin
		if (seq_reg == 8'd0) begin
			reply_byte = slave_addr;
		end else if (seq_reg == 8'd1) begin
			reply_byte = FUNC_READ_HOLDING;
		end else if (seq_reg == 8'd2) begin
			reply_byte = byte_cnt;
		end else if (seq_reg < data_end) begin
			reply_byte = k[0] ? rd_word[7:0] : rd_word[15:8];
		end else if (seq_reg == data_end) begin
			reply_byte = tx_crc_reg[7:0];
		end else begin
			reply_byte = tx_crc_reg[15:8];
		end
	end

	assign fifo_in_data = reply_byte;
	assign fifo_in_valid = (state_reg == ST_SEND);

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always_comb begin
		state_next = state_reg;
		qbuf_next = qbuf_reg;
		qidx_next = qidx_reg;
		rx_crc_next = rx_crc_reg;
		gap_next = gap_reg;
		bad_next = bad_reg;
		start_next = start_reg;
		count_next = count_reg;
		dropped_next = dropped_reg;
		seq_next = seq_reg;
		tx_crc_next = tx_crc_reg;
		unique case (state_reg)
			ST_LISTEN: begin
				if (rx_valid) begin
					gap_next = '0;
					if (qidx_reg < 4'(QUERY_BYTES)) begin
						qbuf_next[qidx_reg[2:0]] = rx_data;
						qidx_next = qidx_reg + 1'b1;
						rx_crc_next = mbr_crc_update(rx_crc_reg, rx_data);
					end else begin
						bad_next = 1'b1;
					end
					if (rx_error) begin
						bad_next = 1'b1;
					end
				end else if (qidx_reg != '0) begin
					if (gap_reg == GW'(GAP_CYCLES - 1)) begin
						if (query_ok) begin
							state_next = ST_SEND;
							start_next = q_start;
							count_next = q_count;
							seq_next = '0;
							tx_crc_next = CRC_INIT;
						end else if (dropped_reg != 8'hff) begin
							dropped_next = dropped_reg + 1'b1;
						end
						qidx_next = '0;
						bad_next = 1'b0;
						rx_crc_next = CRC_INIT;
						gap_next = '0;
					end else begin
						gap_next = gap_reg + 1'b1;
					end
				end
			end
			ST_SEND: begin
				if (fifo_in_ready) begin
					seq_next = seq_reg + 1'b1;
					if (seq_reg < data_end) begin
						tx_crc_next = mbr_crc_update(tx_crc_reg, reply_byte);
					end
					if (seq_reg == data_end + 8'd1) begin
						state_next = ST_DRAIN;
					end
				end
			end
			ST_DRAIN: begin
				// Hold the line until the last stop bit has left
				if (!fifo_out_valid && !uart_tx_busy) begin
					state_next = ST_LISTEN;
				end
			end
		endcase
	end

	// Pins are registered so every output leaves a flip-flop
	always_comb begin
		rs232_txd_next = uart_txd;
		rs485_txd_next = uart_txd;
		rs485_oe_next = rs485_active_reg && (state_reg != ST_LISTEN);
		reply_active_next = (state_next != ST_LISTEN);
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			state_reg <= ST_LISTEN;
			qidx_reg <= '0;
			rx_crc_reg <= CRC_INIT;
			gap_reg <= '0;
			bad_reg <= 1'b0;
			start_reg <= '0;
			count_reg <= '0;
			dropped_reg <= '0;
			seq_reg <= '0;
			tx_crc_reg <= CRC_INIT;
			rs485_active_reg <= 1'b0;
			rs232_txd_reg <= 1'b1;
			rs485_txd_reg <= 1'b1;
			rs485_oe_reg <= 1'b0;
			reply_active_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			qidx_reg <= qidx_next;
			rx_crc_reg <= rx_crc_next;
			gap_reg <= gap_next;
			bad_reg <= bad_next;
			start_reg <= start_next;
			count_reg <= count_next;
			dropped_reg <= dropped_next;
			seq_reg <= seq_next;
			tx_crc_reg <= tx_crc_next;
			rs485_active_reg <= rs485_active_next;
			rs232_txd_reg <= rs232_txd_next;
			rs485_txd_reg <= rs485_txd_next;
			rs485_oe_reg <= rs485_oe_next;
			reply_active_reg <= reply_active_next;
		end
		qbuf_reg <= qbuf_next;
	end

	assign rs232_txd = rs232_txd_reg;
	assign rs485_txd = rs485_txd_reg;
	assign rs485_oe = rs485_oe_reg;
	assign reply_active = reply_active_reg;
	assign dropped_count = dropped_reg;
endmodule
`default_nettype wire

// ### test/mbr_responder_asserts.sv
// Port-level property checker for the register responder
`timescale 1ns/1ps
`default_nettype none
module mbr_checker #(
	parameter int BIT_CYCLES = 16,
	parameter int GAP_CYCLES = 704,
	parameter int NUM_FLOATS = 4
)(
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic [7:0] slave_addr,
	input wire logic rs485_select,
	input wire logic sdi12_select,
	input wire mbr_pkg::mbr_float_type [NUM_FLOATS-1:0] meas_values,
	input wire logic rs232_rxd,
	input wire logic rs485_rxd,
	input wire logic rs232_txd,
	input wire logic rs485_txd,
	input wire logic rs485_oe,
	input wire logic reply_active,
	input wire logic [7:0] dropped_count
);
	import mbr_pkg::*;
	// ----
	// Run-length counters
	// ----
	logic [15:0] low_reg, low_next, idle_reg, idle_next;
	always_comb begin
		low_next = rs232_txd ? 16'h0000 : low_reg + 16'h0001;
		// Saturates so a long idle never wraps back under the gap
		idle_next = !(rs232_rxd & rs485_rxd) ? 16'h0000 : (&idle_reg ? idle_reg : idle_reg + 16'h0001);
	end
	always_ff @(posedge sys_clk) begin
		low_reg <= reset ? 16'h0000 : low_next;
		idle_reg <= reset ? 16'h0000 : idle_next;
	end
	// ----
	// Properties
	// ----
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);
	a_oe_select: assert property (rs485_oe |-> rs485_select && !sdi12_select)
		else $error("rs485 driver on while not selected");
	a_oe_reply: assert property (rs485_oe |-> reply_active || $past(reply_active))
		else $error("rs485 driver on outside a reply");
	a_oe_follows: assert property (rs485_select && !sdi12_select && $past(rs485_select, 2) && !$past(sdi12_select, 2)
		&& reply_active && $past(reply_active) |-> rs485_oe)
		else $error("rs485 driver off during a reply");
	a_idle_mark: assert property (!reply_active && !$past(reply_active) |-> rs232_txd)
		else $error("txd active outside a reply");
	a_twin_lines: assert property (rs485_txd == rs232_txd)
		else $error("serial outputs differ");
	a_reset_state: assert property (disable iff (1'b0) reset |=> rs232_txd && !rs485_oe && !reply_active
		&& dropped_count == 8'h00)
		else $error("outputs not at reset level");
	a_bit_width: assert property ($rose(rs232_txd) |-> low_reg != 16'h0000 && low_reg % BIT_CYCLES == 0)
		else $error("low run not a whole number of bits");
	a_reply_start: assert property ($rose(reply_active) |-> ##[1:10] !rs232_txd)
		else $error("no start bit after reply began");
	a_frame_gap: assert property ($rose(reply_active) |-> idle_reg >= GAP_CYCLES)
		else $error("reply began before the idle gap");
	a_drop_step: assert property ($changed(dropped_count) |-> !reply_active
		&& dropped_count == $past(dropped_count) + 8'h01)
		else $error("drop count step wrong");
	c_reply: cover property ($rose(reply_active));
	c_oe: cover property ($rose(rs485_oe));
	c_drop: cover property ($changed(dropped_count));
endmodule
bind mbr_responder mbr_checker #(.BIT_CYCLES(BIT_CYCLES), .GAP_CYCLES(GAP_CYCLES), .NUM_FLOATS(NUM_FLOATS))
	mbr_checker_inst (.sys_clk(sys_clk), .reset(reset), .slave_addr(slave_addr), .rs485_select(rs485_select),
	.sdi12_select(sdi12_select), .meas_values(meas_values), .rs232_rxd(rs232_rxd), .rs485_rxd(rs485_rxd),
	.rs232_txd(rs232_txd), .rs485_txd(rs485_txd), .rs485_oe(rs485_oe), .reply_active(reply_active),
	.dropped_count(dropped_count));
`default_nettype wire

// ### test/mbr_master_model.sv
// Serial master model: sends query bytes, collects reply bytes
`timescale 1ns/1ps
`default_nettype none
module mbr_master_model #(
	parameter int BIT_CYCLES = 16
)(
	input wire logic sys_clk,
	input wire logic rx_line,
	output logic tx_line
);
	initial tx_line = 1'b1;
	// ----
	// Byte tasks
	// ----
	task automatic send_byte(input logic [7:0] b);
		logic [10:0] fr;
		fr = {1'b0, b, ^b, 1'b1};
		for (int i = 10; i >= 0; i--) begin
			@(posedge sys_clk) tx_line <= fr[i];
			repeat (BIT_CYCLES - 1) @(posedge sys_clk);
		end
	endtask
	// Returns at mid stop bit so the next start edge is never missed
	task automatic get_byte(output logic [7:0] b, output logic ok, input int limit);
		logic [10:0] s;
		int n;
		n = 0;
		while (rx_line !== 1'b0 && n < limit) begin
			@(posedge sys_clk);
			n++;
		end
		repeat (BIT_CYCLES / 2) @(posedge sys_clk);
		for (int i = 10; i >= 0; i--) begin
			s[i] = rx_line;
			if (i > 0) begin
				repeat (BIT_CYCLES) @(posedge sys_clk);
			end
		end
		b = s[9:2];
		ok = n < limit && s[10] === 1'b0 && s[0] === 1'b1 && s[1] === ^s[9:2];
	endtask
endmodule
`default_nettype wire

// ### test/test_mbr_responder.sv
// Self-checking bench for the register responder
`timescale 1ns/1ps
`default_nettype none
module test_mbr_responder;
	import mbr_pkg::*;
	localparam int BITC = 16;
	localparam int GAPC = 704;
	localparam int NF = 4;
	logic sys_clk, reset, rs485_select, sdi12_select, use485, ok, x, sp;
	logic [7:0] slave_addr, dropped_count, got, prev, a, f;
	logic [15:0] s, c;
	mbr_float_type [NF-1:0] meas_values;
	logic rs232_txd, rs485_txd, rs485_oe, reply_active, m_tx;
	logic [7:0] exp_q[$];
	logic [49:0] bad_tab[6];
	int n_errors = 0;
	int total_checks = 0;
	wire logic rs232_rxd = use485 ? 1'b1 : m_tx;
	wire logic rs485_rxd = use485 ? m_tx : 1'b1;
	// Released pair idles high through the bias network
	wire logic m_rx = use485 ? (rs485_oe ? rs485_txd : 1'b1) : rs232_txd;
	mbr_responder #(.BIT_CYCLES(BITC), .GAP_CYCLES(GAPC), .NUM_FLOATS(NF), .FIFO_DEPTH(32)) mbr_responder_inst (
		.sys_clk(sys_clk), .reset(reset), .slave_addr(slave_addr), .rs485_select(rs485_select),
		.sdi12_select(sdi12_select), .meas_values(meas_values), .rs232_rxd(rs232_rxd), .rs485_rxd(rs485_rxd),
		.rs232_txd(rs232_txd), .rs485_txd(rs485_txd), .rs485_oe(rs485_oe), .reply_active(reply_active),
		.dropped_count(dropped_count));
	mbr_master_model #(.BIT_CYCLES(BITC)) mbr_master_model_inst (.sys_clk(sys_clk), .rx_line(m_rx), .tx_line(m_tx));
	// ----
	// Helpers
	// ----
	task automatic summarize();
		$display("checks %0d, mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [7:0] e, input logic [7:0] g);
		total_checks++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected %s: expected %h, seen %h", what, e, g);
		end
	endtask
	function automatic logic [15:0] crc16(input logic [7:0] q[$]);
		logic [15:0] r;
		r = 16'hffff;
		foreach (q[i]) begin
			r ^= {8'h00, q[i]};
			for (int k = 0; k < 8; k++) begin
				r = r[0] ? (r >> 1) ^ 16'ha001 : r >> 1;
			end
		end
		return r;
	endfunction
	task automatic send(input logic [7:0] ad, fc, input logic [15:0] st, ct, input logic bad, split);
		logic [7:0] q[$];
		logic [15:0] cr;
		q = '{ad, fc, st[15:8], st[7:0], ct[15:8], ct[7:0]};
		cr = crc16(q) ^ {15'h0000, bad};
		q.push_back(cr[7:0]);
		q.push_back(cr[15:8]);
		foreach (q[i]) begin
			if (split && i == 4) begin
				repeat (GAPC + 2 * BITC) @(posedge sys_clk);
			end
			mbr_master_model_inst.send_byte(q[i]);
		end
	endtask
	task automatic build_exp(input logic [15:0] st, ct);
		logic [15:0] r, w, cr;
		exp_q = '{slave_addr, 8'h03, 8'(2 * ct)};
		for (int k = 0; k < ct; k++) begin
			r = st + 16'(k);
			w = r[0] ? meas_values[r[15:1]].high_word : meas_values[r[15:1]].low_word;
			exp_q.push_back(w[15:8]);
			exp_q.push_back(w[7:0]);
		end
		cr = crc16(exp_q);
		exp_q.push_back(cr[7:0]);
		exp_q.push_back(cr[15:8]);
	endtask
	task automatic rx_check();
		foreach (exp_q[i]) begin
			mbr_master_model_inst.get_byte(got, ok, 4 * GAPC);
			if (ok !== 1'b1) begin
				$display("unexpected reply frame %0d: expected 1, seen %b", i, ok);
				n_errors++;
				summarize();
			end
			check("reply byte", exp_q[i], got);
		end
	endtask
	// Next query only once the reply is over, so the pair never collides
	task automatic wait_idle();
		for (int n = 0; reply_active !== 1'b0; n++) begin
			@(posedge sys_clk);
			if (n > 4 * GAPC) begin
				$display("unexpected reply_active: expected 0, seen %b", reply_active);
				n_errors++;
				summarize();
			end
		end
		repeat (4) @(posedge sys_clk);
	endtask
	// ----
	// Sequence
	// ----
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	initial begin
		reset = 1'b1;
		slave_addr = 8'h01;
		rs485_select = 1'b0;
		sdi12_select = 1'b0;
		use485 = 1'b0;
		meas_values = {32'h4106a8c9, 32'h9abcdef0, 32'h12345678, 32'h3fc7ae14};
		bad_tab = '{{8'h01, 8'h03, 16'h0006, 16'h0002, 2'b10}, {8'h02, 8'h03, 16'h0006, 16'h0002, 2'b00},
			{8'h01, 8'h04, 16'h0006, 16'h0002, 2'b00}, {8'h01, 8'h03, 16'h0000, 16'h0000, 2'b00},
			{8'h01, 8'h03, 16'h0007, 16'h0002, 2'b00}, {8'h01, 8'h03, 16'h0006, 16'h0002, 2'b01}};
		repeat (20) @(posedge sys_clk);
		reset <= 1'b0;
		@(posedge sys_clk);
		send(8'h01, 8'h03, 16'h0006, 16'h0002, 1'b0, 1'b0);
		exp_q = '{8'h01, 8'h03, 8'h04, 8'ha8, 8'hc9, 8'h41, 8'h06, 8'hba, 8'h3f};
		rx_check();
		wait_idle();
		$display("test ph_example done");
		rs485_select <= 1'b1;
		use485 <= 1'b1;
		repeat (4) @(posedge sys_clk);
		for (int t = 0; t < 2; t++) begin
			s = t ? 16'h0005 : 16'h0000;
			c = t ? 16'h0003 : 16'h0008;
			send(slave_addr, 8'h03, s, c, 1'b0, 1'b0);
			build_exp(s, c);
			rx_check();
			wait_idle();
		end
		$display("test rs485_map done");
		sdi12_select <= 1'b1;
		use485 <= 1'b0;
		repeat (4) @(posedge sys_clk);
		send(slave_addr, 8'h03, 16'h0002, 16'h0002, 1'b0, 1'b0);
		build_exp(16'h0002, 16'h0002);
		rx_check();
		wait_idle();
		$display("test sdi12_owns_pair done");
		sdi12_select <= 1'b0;
		rs485_select <= 1'b0;
		foreach (bad_tab[i]) begin
			{a, f, s, c, x, sp} = bad_tab[i];
			prev = dropped_count;
			send(a, f, s, c, x, sp);
			mbr_master_model_inst.get_byte(got, ok, GAPC + 400);
			check("silent drop", 8'h00, {7'h00, ok});
			check("dropped_count", prev + (sp ? 8'h02 : 8'h01), dropped_count);
		end
		slave_addr <= 8'hf7;
		@(posedge sys_clk);
		send(8'hf7, 8'h03, 16'h0007, 16'h0001, 1'b0, 1'b0);
		build_exp(16'h0007, 16'h0001);
		rx_check();
		wait_idle();
		$display("test refusals done");
		summarize();
	end
endmodule
`default_nettype wire
